// *** shared/vsw_pkg.sv ***
`default_nettype none
package vsw_pkg;
  // Register offsets (byte addresses within the register space)
  localparam logic [11:0] OFS_WIN7_BASE = 12'hfd0;
  localparam logic [11:0] OFS_WIN7_BOUND = 12'hfd4;
  localparam logic [11:0] OFS_WIN7_OFFSET = 12'hfd8;
  localparam logic [11:0] OFS_CFG_CLEAR = 12'hff4;
  localparam logic [11:0] OFS_CFG_SET = 12'hff8;
  localparam logic [11:0] OFS_CFG_BASE = 12'hffc;

  // Field positions
  localparam int WIN_FIELD_LSB = 16;
  localparam int WIN_FIELD_W = 16;
  localparam int CFG_RESET_BIT = 31;
  localparam int CFG_SYSFAIL_BIT = 30;
  localparam int CFG_FAIL_BIT = 29;
  localparam int CFG_BASE_LSB = 27;
  localparam int CFG_BASE_W = 5;
  localparam int CSR_ADDR_LSB = 19;
  localparam int CSR_ADDR_W = 24;
  localparam int BYTE_LANE_TOP = 3;

  // Reset values and fixed encodings
  localparam logic [15:0] WIN_FIELD_RST = 16'h0000;
  localparam logic [4:0] CFG_BASE_RST = 5'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [15:0] BOUND_OPEN = 16'h0000;
  localparam logic [4:0] CFG_BASE_NONE = 5'h00;
  localparam logic BOARD_FAIL = 1'b0;

  typedef struct packed {
    logic [15:0] win_base;
    logic [15:0] win_bound;
    logic [15:0] win_shift;
    logic [4:0] cfg_base;
    logic local_reset;
    logic bus_fail;
    logic strap_done;
    logic [31:0] rdata;
    logic ack;
    logic claim;
    logic [31:0] pci_addr;
    logic csr_hit;
  } vsw_state_type;
endpackage
`default_nettype wire

// *** hw/vsw_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
// How it works
// - The window base field in the upper sixteen address bits is the lowest address the image decodes.
// - A cycle is claimed only when its address is at or above the base and strictly below the bound.
// - A bound of zero removes the upper limit so everything at or above the base is claimed.
// - The PCI address is the source address plus the translation shift, negative shifts in two's complement.
// - No cycle is claimed unless the bus master enable of the PCI command/status register is set.
// - The board reset bit reads back the local reset state and a 1 written to the clear register releases it.
// - A 1 written to the board reset bit of the set register asserts the local reset toward PCI.
// - The local reset stays asserted until a 1 is written to the clear register's board reset bit or rst_n goes low.
// - The bus fail bit reads the bus fail drive, is set by a 1 to the set register and cleared by a 1 to the clear register.
// - The board fault bit is read-only in both registers and always reads 0, meaning no failure.
// - The CR/CSR base field picks one of 31 windows of 512 Kbytes in configuration space.
// - Base bits 31 to 27 are compared with VMEbus address lines 23 to 19 to decide a CR/CSR hit.
module vsw_ctrl
  import vsw_pkg::*;
(
  input wire logic sys_clk,            // System clock, 125 MHz
  input wire logic rst_n,              // Asynchronous reset, active low
  input wire logic sysfail_strap,      // Power-up value of the bus fail drive
  input wire logic reg_wr,             // Register write strobe
  input wire logic reg_rd,             // Register read strobe
  input wire logic [11:0] reg_addr,    // Register byte address
  input wire logic [3:0] reg_be,       // Byte enables, lane 3 = bits 31:24
  input wire logic [31:0] reg_wdata,   // Register write data
  output logic [31:0] reg_rdata,       // Read data, valid with reg_ack
  output logic reg_ack,                // One-cycle access acknowledge
  input wire logic bus_master_enable,  // Bus master enable from PCI_COMMAND_STATUS_REG
  input wire logic slave_req,          // Incoming VMEbus slave cycle, pulse
  input wire logic [31:0] slave_addr,  // VMEbus address of that cycle
  output logic slave_claim,            // Image claims the cycle, pulse
  output logic [31:0] pci_addr,        // Translated PCI address
  input wire logic csr_req,            // Incoming CR/CSR cycle, pulse
  input wire logic [23:0] csr_addr,    // A24 address of CR/CSR cycle
  output logic csr_hit,                // CR/CSR cycle targets us, pulse
  output logic local_reset_out_n,      // Local reset toward PCI, active low
  output logic bus_fail_drive          // Drives the bus fail line when high
);

  //////////////////////////////////////////////////////////////////////////
  vsw_state_type state;
  vsw_state_type next_state;
  logic wr_top;
  logic [15:0] src_page;
  logic above_base;
  logic below_bound;
  logic [31:0] status_word;
  logic sel_win_base;
  logic sel_win_bound;
  logic sel_win_shift;
  logic sel_cfg_clear;
  logic sel_cfg_set;
  logic sel_cfg_base;
  logic [15:0] win_lane_mask;
  logic [15:0] win_wdata;
  logic [31:0] read_word;

  // Set, clear and base registers only act on the top byte lane
  assign wr_top = reg_wr && reg_be[BYTE_LANE_TOP];
  assign src_page = slave_addr[31:WIN_FIELD_LSB];
  assign above_base = src_page >= state.win_base;
  assign below_bound = (state.win_bound == BOUND_OPEN)
    || (src_page < state.win_bound);

  // Both set and clear registers read back this one word
  always_comb begin
    status_word = RDATA_RST;
    status_word[CFG_RESET_BIT] = state.local_reset;
    status_word[CFG_SYSFAIL_BIT] = state.bus_fail;
    status_word[CFG_FAIL_BIT] = BOARD_FAIL;
  end

  //////////////////////////////////////////////////////////////////////////
  // One decoder serves reads and writes, so the two can never disagree
  // on which register an offset selects
  always_comb begin
    sel_win_base = 1'b0;
    sel_win_bound = 1'b0;
    sel_win_shift = 1'b0;
    sel_cfg_clear = 1'b0;
    sel_cfg_set = 1'b0;
    sel_cfg_base = 1'b0;
    if (reg_addr == OFS_WIN7_BASE) begin
      sel_win_base = 1'b1;
    end else if (reg_addr == OFS_WIN7_BOUND) begin
      sel_win_bound = 1'b1;
    end else if (reg_addr == OFS_WIN7_OFFSET) begin
      sel_win_shift = 1'b1;
    end else if (reg_addr == OFS_CFG_CLEAR) begin
      sel_cfg_clear = 1'b1;
    end else if (reg_addr == OFS_CFG_SET) begin
      sel_cfg_set = 1'b1;
    end else if (reg_addr == OFS_CFG_BASE) begin
      sel_cfg_base = 1'b1;
    end
  end

  // Window fields sit in the upper half word; each of its byte lanes is
  // written on its own so that byte-wide masters can load them too
  for (genvar lane = 0; lane < 2; lane++) begin : g_win_lane
    assign win_lane_mask[8*lane +: 8] = {8{reg_be[WIN_FIELD_LSB/8 + lane]}};
  end
  assign win_wdata = reg_wdata[31:WIN_FIELD_LSB];

  // Read mux; reserved bits and unmapped offsets return zero
  always_comb begin
    read_word = RDATA_RST;
    if (sel_win_base) begin
      read_word = {state.win_base, 16'h0000};
    end else if (sel_win_bound) begin
      read_word = {state.win_bound, 16'h0000};
    end else if (sel_win_shift) begin
      read_word = {state.win_shift, 16'h0000};
    end else if (sel_cfg_clear || sel_cfg_set) begin
      read_word = status_word;
    end else if (sel_cfg_base) begin
      read_word = {state.cfg_base, 27'h000_0000};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_state.ack = reg_wr || reg_rd;
    next_state.claim = 1'b0;
    next_state.csr_hit = 1'b0;

    // Strap is caught on the first clock after reset release, never
    // through the asynchronous reset itself
    if (!state.strap_done) begin
      next_state.strap_done = 1'b1;
      next_state.bus_fail = sysfail_strap;
    end

    // Writes: only the enabled lanes of a window field change
    if (reg_wr) begin
      if (sel_win_base) begin
        next_state.win_base = (state.win_base & ~win_lane_mask)
          | (win_wdata & win_lane_mask);
      end else if (sel_win_bound) begin
        next_state.win_bound = (state.win_bound & ~win_lane_mask)
          | (win_wdata & win_lane_mask);
      end else if (sel_win_shift) begin
        next_state.win_shift = (state.win_shift & ~win_lane_mask)
          | (win_wdata & win_lane_mask);
      end else if (sel_cfg_clear) begin
        if (wr_top && reg_wdata[CFG_RESET_BIT]) begin
          next_state.local_reset = 1'b0;
        end
        if (wr_top && reg_wdata[CFG_SYSFAIL_BIT]) begin
          next_state.bus_fail = 1'b0;
        end
      end else if (sel_cfg_set) begin
        if (wr_top && reg_wdata[CFG_RESET_BIT]) begin
          next_state.local_reset = 1'b1;
        end
        if (wr_top && reg_wdata[CFG_SYSFAIL_BIT]) begin
          next_state.bus_fail = 1'b1;
        end
      end else if (sel_cfg_base) begin
        // Only the top byte lane holds the field, so a byte write is
        // enough and other lanes are ignored
        if (wr_top) begin
          next_state.cfg_base = reg_wdata[31:CFG_BASE_LSB];
        end
      end
    end

    // Read data is registered and holds until the next read, so a slow
    // master may pick it up after the acknowledge has gone
    if (reg_rd) begin
      next_state.rdata = read_word;
    end

    // Slave image decode and translation; the 32-bit sum wraps on
    // purpose so that a two's complement shift moves the window down
    if (slave_req && bus_master_enable && above_base && below_bound) begin
      next_state.claim = 1'b1;
      next_state.pci_addr = slave_addr
        + {state.win_shift, 16'h0000};
    end

    // A base of zero selects no window, leaving 31 usable slots
    if (csr_req && state.cfg_base != CFG_BASE_NONE
        && csr_addr[CSR_ADDR_W-1:CSR_ADDR_LSB] == state.cfg_base) begin
      next_state.csr_hit = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state.win_base <= WIN_FIELD_RST;
      state.win_bound <= WIN_FIELD_RST;
      state.win_shift <= WIN_FIELD_RST;
      state.cfg_base <= CFG_BASE_RST;
      state.local_reset <= 1'b0;
      state.bus_fail <= 1'b0;
      state.strap_done <= 1'b0;
      state.rdata <= RDATA_RST;
      state.ack <= 1'b0;
      state.claim <= 1'b0;
      state.pci_addr <= RDATA_RST;
      state.csr_hit <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign reg_ack = state.ack;
  assign slave_claim = state.claim;
  assign pci_addr = state.pci_addr;
  assign csr_hit = state.csr_hit;
  assign local_reset_out_n = !state.local_reset;
  assign bus_fail_drive = state.bus_fail;

endmodule
`default_nettype wire

// *** dv/vsw_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module vsw_assertions
  import vsw_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [11:0] reg_addr, // Address
  input wire logic [3:0] reg_be, // Lanes
  input wire logic [31:0] reg_wdata, // Data
  input wire logic reg_ack, // Ack
  input wire logic bus_master_enable, // Enable
  input wire logic slave_req, // Cycle
  input wire logic slave_claim, // Claim
  input wire logic [31:0] pci_addr, // Address out
  input wire logic local_reset_out_n, // Reset out
  input wire logic bus_fail_drive // Fail out
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  wire logic set_wr = reg_wr && reg_be[3] && reg_addr == OFS_CFG_SET;
  wire logic clr_wr = reg_wr && reg_be[3] && reg_addr == OFS_CFG_CLEAR;
  a_ack_after_access: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("no ack after access");
  a_ack_only_access: assert property (!(reg_wr || reg_rd) |=> !reg_ack)
    else $error("stray ack");
  a_claim_has_cause: assert property (
    slave_claim |-> $past(slave_req && bus_master_enable))
    else $error("claim without enabled cycle");
  a_shift_addr_holds: assert property (!slave_claim |-> $stable(pci_addr))
    else $error("address moved without claim");
  a_reset_set: assert property (set_wr && reg_wdata[31] |=> !local_reset_out_n)
    else $error("local reset not asserted");
  a_reset_clear: assert property (clr_wr && reg_wdata[31] |=> local_reset_out_n)
    else $error("local reset not released");
  a_reset_sticky: assert property (
    !local_reset_out_n && !(clr_wr && reg_wdata[31]) |=> !local_reset_out_n)
    else $error("local reset dropped by itself");
  a_fail_set: assert property (set_wr && reg_wdata[30] |=> bus_fail_drive)
    else $error("bus fail not driven");
  a_fail_clear: assert property (clr_wr && reg_wdata[30] |=> !bus_fail_drive)
    else $error("bus fail not released");
endmodule
bind vsw_ctrl vsw_assertions u_chk (.sys_clk, .rst_n, .reg_wr, .reg_rd,
  .reg_addr, .reg_be, .reg_wdata, .reg_ack, .bus_master_enable, .slave_req,
  .slave_claim, .pci_addr, .local_reset_out_n, .bus_fail_drive);
`default_nettype wire

// *** dv/vsw_vme_master.sv ***
`timescale 1ns/10ps
`default_nettype none
module vsw_vme_master (
  input wire logic sys_clk, // Clock
  output logic req, // Slave cycle strobe
  output logic [31:0] addr, // Slave address
  output logic creq, // CR/CSR cycle strobe
  output logic [23:0] caddr // CR/CSR address
);
  initial begin
    {req, creq, addr, caddr} = '0;
  end
  // Lines flip outside a cycle so a stale address can never match
  task automatic cycle(input logic csr, input logic [31:0] a);
    @(posedge sys_clk);
    {req, creq, addr, caddr} <= {!csr, csr, a, a[23:0]};
    @(posedge sys_clk);
    {req, creq, addr, caddr} <= {2'b00, ~a, ~a[23:0]};
  endtask
endmodule
`default_nettype wire

// *** dv/vsw_ctrl_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module vsw_ctrl_tb_top;
  import vsw_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, sysfail_strap = 1'b1, en, rd_d = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, bus_master_enable = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [3:0] reg_be = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, pci_addr, slave_addr, a;
  logic [23:0] csr_addr;
  logic reg_ack, slave_claim, slave_req, csr_req, csr_hit;
  logic local_reset_out_n, bus_fail_drive;
  logic [15:0] base, bound, shift, hi;
  logic [4:0] k;
  logic [31:0] rq[$], pq[$];
  int failures = 0, cmp_count = 0, hits_exp = 0, hits = 0;
  always #4 sys_clk = ~sys_clk;
  vsw_ctrl dut (.sys_clk, .rst_n, .sysfail_strap, .reg_wr, .reg_rd, .reg_addr,
    .reg_be, .reg_wdata, .reg_rdata, .reg_ack, .bus_master_enable, .slave_req,
    .slave_addr, .slave_claim, .pci_addr, .csr_req, .csr_addr, .csr_hit,
    .local_reset_out_n, .bus_fail_drive);
  vsw_vme_master vme (.sys_clk, .req(slave_req), .addr(slave_addr),
    .creq(csr_req), .caddr(csr_addr));
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    #1;
    if (reg_ack === 1'b1 && rd_d === 1'b1)
      `CHK(reg_rdata, rq.pop_front())
    if (slave_claim === 1'b1) `CHK(pci_addr, pq.pop_front())
    if (csr_hit === 1'b1) hits++;
  end
  // A read carries its expected data in d
  task automatic acc(input logic w, input logic [11:0] ad, input logic [3:0] be,
    input logic [31:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_rd, reg_addr, reg_be, reg_wdata} <= {w, !w, ad, be, d};
    if (!w) rq.push_back(d);
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'b00;
    @(posedge sys_clk);
  endtask
  task automatic end_sim;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    end_sim;
  end
  initial begin
    void'($urandom(951));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    acc(0, OFS_WIN7_BASE, 4'hf, 32'h0000_0000);
    acc(0, OFS_WIN7_BOUND, 4'hf, 32'h0000_0000);
    acc(0, OFS_WIN7_OFFSET, 4'hf, 32'h0000_0000);
    acc(0, OFS_CFG_CLEAR, 4'hf, 32'h4000_0000);
    acc(0, OFS_CFG_BASE, 4'h8, 32'h0000_0000);
    acc(0, 12'hf00, 4'hf, 32'h0000_0000);
    $display("test reset values done");
    acc(1, OFS_CFG_SET, 4'h8, 32'ha000_0000);
    `CHK(local_reset_out_n, 1'b0)
    acc(1, OFS_CFG_CLEAR, 4'h8, 32'h4000_0000);
    acc(0, OFS_CFG_SET, 4'hf, 32'h8000_0000);
    `CHK(bus_fail_drive, 1'b0)
    acc(1, OFS_CFG_CLEAR, 4'h8, 32'h8000_0000);
    acc(1, OFS_CFG_SET, 4'h8, 32'h4000_0000);
    acc(0, OFS_CFG_CLEAR, 4'hf, 32'h4000_0000);
    `CHK(local_reset_out_n, 1'b1)
    $display("test status bits done");
    acc(1, OFS_CFG_SET, 4'h8, 32'hc000_0000);
    sysfail_strap <= 1'b0;
    rst_n <= 1'b0;
    @(posedge sys_clk);
    `CHK({local_reset_out_n, bus_fail_drive}, 2'b10)
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    acc(0, OFS_CFG_SET, 4'hf, 32'h0000_0000);
    acc(0, OFS_WIN7_BASE, 4'hf, 32'h0000_0000);
    $display("test mid-run reset done");
    for (int r = 0; r < 2; r++) begin
      base = 16'($urandom_range(16'h7fff, 16'h0010));
      bound = r ? 16'h0000 : base + 16'h0010;
      shift = 16'($urandom);
      acc(1, OFS_WIN7_BASE, 4'hc, {base, 16'h0000});
      acc(1, OFS_WIN7_BOUND, 4'hc, {bound, 16'h0000});
      acc(1, OFS_WIN7_OFFSET, 4'hc, {shift, 16'h0000});
      acc(0, OFS_WIN7_BASE, 4'hf, {base, 16'h0000});
      acc(0, OFS_WIN7_BOUND, 4'hf, {bound, 16'h0000});
      acc(0, OFS_WIN7_OFFSET, 4'hf, {shift, 16'h0000});
      repeat (24) begin
        hi = base - 16'h0004 + 16'($urandom_range(24));
        a = {hi, 16'($urandom)};
        en = ($urandom_range(3) != 0);
        bus_master_enable <= en;
        if (en && hi >= base && (bound == 0 || hi < bound))
          pq.push_back(a + {shift, 16'h0000});
        vme.cycle(1'b0, a);
      end
    end
    $display("test window done");
    for (int j = 0; j < 4; j++) begin
      k = j ? 5'($urandom_range(31, 1)) : 5'h00;
      acc(1, OFS_CFG_BASE, 4'h8, {k, 27'h000_0000});
      acc(0, OFS_CFG_BASE, 4'h8, {k, 27'h000_0000});
      hits_exp += (k != 0);
      vme.cycle(1'b1, {8'h00, k, 19'($urandom)});
      vme.cycle(1'b1, {8'h00, k ^ 5'h01, 19'h0_0000});
    end
    repeat (3) @(posedge sys_clk);
    `CHK(hits, hits_exp)
    `CHK(pq.size(), 0)
    `CHK(rq.size(), 0)
    $display("test csr window done");
    end_sim;
  end
endmodule
`default_nettype wire
